// ### inc/ssm_consts.svh
// Purpose: offsets, field positions, reset values and widths for the switch status memory
// Assumes: byte-wide status memory of eight locations
// Notes:   definitions only
`ifndef SSM_CONSTS_SVH
`define SSM_CONSTS_SVH

`define SSM_ADDR_LOCK       3'h0
`define SSM_ADDR_REDIR0     3'h1
`define SSM_ADDR_REDIR3     3'h4
`define SSM_ADDR_FACTORY    3'h5
`define SSM_ADDR_DEFAULTS   3'h6
`define SSM_ADDR_LIVE       3'h7

`define SSM_LOCK_LSB        0
`define SSM_LOCK_MSB        3
`define SSM_SRCH_POL        0
`define SSM_SRCH_SRC_LO     1
`define SSM_SRCH_SRC_HI     2
`define SSM_SRCH_MSB        4
`define SSM_SW_A            5
`define SSM_SW_B            6
`define SSM_SUPPLY          7

`define SSM_ERASED          8'hFF
`define SSM_FACTORY_VAL     8'h00
`define SSM_REDIR_FIXED     8'hFC
`define SSM_LIVE_RST        8'h60
`define SSM_LIVE_WMASK      8'h7F
`define SSM_PAGE_BYTES      32

`endif

// ### inc/ssm_pkg.sv
// Purpose: types shared by the switch status memory files
// Assumes: constants live in ssm_consts.svh
// Notes:   types only
package ssm_pkg;
    typedef enum logic [1:0] {
        SSM_ST_POWERUP = 2'b00,
        SSM_ST_RUN     = 2'b01,
        SSM_ST_HIDDEN  = 2'b10
    } ssm_state_t;
endpackage : ssm_pkg

// ### src/ssm_otp_cell.sv
// Purpose: one byte of one-time-programmable status storage
// Assumes: programming only clears bits; erased bits read as one
// Notes:   fixed_ones marks bits that can never be cleared
`timescale 1ns/10ps
`include "ssm_consts.svh"
module ssm_otp_cell #(
    parameter logic [7:0] FIXED_ONES = 8'h00
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       prog,
    input  wire logic [7:0] prog_data,
    output logic      [7:0] q
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // sim reset models a fresh erased part; real cells hold across power
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= `SSM_ERASED; // R22
        end else if (prog) begin
            q <= q & (prog_data | FIXED_ONES); // R5 R6
        end
    end
endmodule : ssm_otp_cell

// ### src/ssm_status_mem.sv
// Purpose: eight-byte status memory of a dual open-drain switch
// Assumes: command decoder on same clock presents address, data, strobes
// Notes:   pins from outside pass a two-flop synchroniser
`timescale 1ns/10ps
`include "ssm_consts.svh"

// Function
// R1: refuse data programming on locked pages
// R2: locked pages still readable
// R3: page-used flags are storage only
// R4: redirection bytes are storage only
// R5: programming only clears bits
// R6: redirect upper six bits never clear
// R7: factory byte reads zero
// R8: address six holds power-on defaults
// R9: defaults copied on first ROM command
// R10: both source selects zero means concealed
// R11: concealed search needs polarity one
// R12: concealment ends at reset or match-write
// R13: channel flops reachable at address seven and command
// R14: flop zero turns transistor on
// R15: transistors off until defaults transferred
// R16: bit seven reads external supply
// R17: channel info byte reports flops and supply
// R18: address seven volatile, loaded from six
// R19: master applies programming pulse on writes
// R20: write returns CRC over command, address, data
// R21: live writes immediate, bit seven ignored
// R22: unprogrammed bits read one
module ssm_status_mem #(
    parameter int PAGES = 4
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        rom_cmd_stb,
    input  wire logic        rom_matched,
    input  wire logic [2:0]  stat_addr,
    input  wire logic [7:0]  stat_wdata,
    input  wire logic        stat_prog,
    input  wire logic        live_wr,
    input  wire logic        chan_wr,
    input  wire logic [1:0]  chan_wdata,
    input  wire logic [7:0]  crc_cmd,
    input  wire logic [15:0] crc_addr,
    output logic      [15:0] write_crc,
    output logic      [7:0]  stat_rdata,
    input  wire logic [6:0]  data_page_addr,
    input  wire logic        data_prog_req,
    output logic             data_prog_ok,
    input  wire logic        supply_pin,
    input  wire logic        switch_a_pin,
    input  wire logic        switch_b_pin,
    output logic             switch_a_oe,
    output logic             switch_b_oe,
    output logic             switch_a_out,
    output logic             switch_b_out,
    output logic      [7:0]  chan_info,
    output logic             concealed,
    output logic             search_eligible
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;

    // first stage read only by second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
        end else begin
            pin_s1_r <= {switch_b_pin, switch_a_pin, supply_pin};
            pin_s2_r <= pin_s1_r;
        end
    end

    // ------------------------------------------------------------
    // otp bytes 0..4 and 6
    // ------------------------------------------------------------
    logic [7:0] otp_q [0:6];
    logic [7:0] wr_mux;

    // status programming commits the scratchpad byte on the pulse
    assign wr_mux = stat_wdata;

    ssm_otp_cell #(.FIXED_ONES(8'h00)) u_lock (
        .clk       (clk),
        .rst       (rst),
        .prog      (stat_prog && stat_addr == `SSM_ADDR_LOCK), // R3
        .prog_data (wr_mux),
        .q         (otp_q[0])
    );

    genvar gi;
    generate
        for (gi = 1; gi <= PAGES; gi++) begin : g_redir
            // redirect contents never steer any access path
            ssm_otp_cell #(.FIXED_ONES(`SSM_REDIR_FIXED)) u_redir ( // R6
                .clk       (clk),
                .rst       (rst),
                .prog      (stat_prog && stat_addr == 3'(gi)), // R4
                .prog_data (wr_mux),
                .q         (otp_q[gi])
            );
        end
    endgenerate

    assign otp_q[5] = `SSM_FACTORY_VAL; // R7

    ssm_otp_cell #(.FIXED_ONES(8'h00)) u_defaults (
        .clk       (clk),
        .rst       (rst),
        .prog      (stat_prog && stat_addr == `SSM_ADDR_DEFAULTS), // R8
        .prog_data (wr_mux),
        .q         (otp_q[6])
    );

    // ------------------------------------------------------------
    // write protection of data pages
    // ------------------------------------------------------------
    logic [1:0]       page_idx;
    logic [PAGES-1:0] page_open;
    logic             page_writable;

    // 32-byte pages: the two top address bits pick the page
    assign page_idx = data_page_addr[6:5];

    // lock bits sit in the low half of byte zero; erased (one) means open
    assign page_open = otp_q[0][`SSM_LOCK_LSB +: PAGES]; // R1

    // upper half of byte zero is never looked at here
    assign page_writable = page_open[page_idx]; // R3

    // programmed lock bit is zero; reads are never gated
    assign data_prog_ok = data_prog_req && page_writable; // R1 R2

    // ------------------------------------------------------------
    // power-up transfer and concealed state
    // ------------------------------------------------------------
    // bit seven is never stored, so the byte-wide constants are cut to seven bits
    localparam logic [7:0] LIVE_RST_BYTE   = `SSM_LIVE_RST;
    localparam logic [7:0] LIVE_WMASK_BYTE = `SSM_LIVE_WMASK;
    localparam logic [6:0] LIVE_RST        = LIVE_RST_BYTE[6:0];
    localparam logic [6:0] LIVE_WMASK      = LIVE_WMASK_BYTE[6:0];

    ssm_pkg::ssm_state_t state_r;
    logic [6:0]          live_r;
    logic [6:0]          live_wdata;
    logic                src_zero;
    logic                powered_up;

    // both source selects cleared is the hiding condition
    assign src_zero = !live_r[`SSM_SRCH_SRC_LO] && !live_r[`SSM_SRCH_SRC_HI];

    // live writes wait for the transfer; until then the byte holds switch-off
    assign powered_up = state_r != ssm_pkg::SSM_ST_POWERUP;

    // supply bit is read-only, so only the stored bits pass
    assign live_wdata = stat_wdata[6:0] & LIVE_WMASK; // R21

    // live byte is volatile: reset means power-up, all switches off
    always_ff @(posedge clk) begin
        if (rst) begin
            live_r <= LIVE_RST; // R15 R18
        end else if (!powered_up && rom_cmd_stb) begin
            live_r <= otp_q[6][6:0]; // R9
        end else if (live_wr && powered_up) begin
            live_r <= live_wdata; // R21
        end else if (chan_wr && powered_up) begin
            live_r[`SSM_SW_B:`SSM_SW_A] <= chan_wdata; // R13
        end
    end

    // hidden leaves only at reset or through a matched write that sets a source bit
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ssm_pkg::SSM_ST_POWERUP; // R12
        end else begin
            case (state_r)
                ssm_pkg::SSM_ST_POWERUP: begin
                    if (rom_cmd_stb) begin
                        state_r <= ssm_pkg::SSM_ST_RUN;
                    end
                end
                ssm_pkg::SSM_ST_RUN: begin
                    if (src_zero) begin
                        state_r <= ssm_pkg::SSM_ST_HIDDEN; // R10
                    end
                end
                ssm_pkg::SSM_ST_HIDDEN: begin
                    if (!src_zero && rom_matched) begin
                        state_r <= ssm_pkg::SSM_ST_RUN; // R12
                    end
                end
                default: begin
                    state_r <= ssm_pkg::SSM_ST_POWERUP;
                end
            endcase
        end
    end

    assign concealed       = state_r == ssm_pkg::SSM_ST_HIDDEN;           // R10
    assign search_eligible = !concealed || live_r[`SSM_SRCH_POL];         // R11

    // ------------------------------------------------------------
    // open-drain drive
    // ------------------------------------------------------------
    // flop zero pulls the pin low; one releases it
    assign switch_a_out = 1'b0;
    assign switch_b_out = 1'b0;
    assign switch_a_oe  = !live_r[`SSM_SW_A]; // R14
    assign switch_b_oe  = !live_r[`SSM_SW_B]; // R14

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [7:0] live_rd;
    logic [7:0] rd_mux;

    // supply bit comes from the synchronised pin, never from a stored bit
    assign live_rd = {pin_s2_r[0], live_r}; // R16

    // every address decoded explicitly so no index runs past the array
    always_comb begin
        case (stat_addr)
            `SSM_ADDR_LOCK: begin
                rd_mux = otp_q[0]; // R2
            end
            `SSM_ADDR_REDIR0: begin
                rd_mux = otp_q[1]; // R22
            end
            3'h2: begin
                rd_mux = otp_q[2];
            end
            3'h3: begin
                rd_mux = otp_q[3];
            end
            `SSM_ADDR_REDIR3: begin
                rd_mux = otp_q[4];
            end
            `SSM_ADDR_FACTORY: begin
                rd_mux = otp_q[5]; // R7
            end
            `SSM_ADDR_DEFAULTS: begin
                rd_mux = otp_q[6];
            end
            `SSM_ADDR_LIVE: begin
                rd_mux = live_rd;
            end
            default: begin
                rd_mux = `SSM_ERASED;
            end
        endcase
    end

    // registered so read data stands a full cycle after the address
    always_ff @(posedge clk) begin
        if (rst) begin
            stat_rdata <= 8'h00;
            chan_info  <= 8'h00;
        end else begin
            stat_rdata <= rd_mux; // R22
            // info: supply, pin levels, flops
            chan_info  <= {pin_s2_r[0], 3'h0, pin_s2_r[2:1], live_r[`SSM_SW_B:`SSM_SW_A]}; // R17
        end
    end

    // ------------------------------------------------------------
    // write crc: cmd, addr lo, addr hi, data, lsb first
    // ------------------------------------------------------------
    function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        logic        fb;
        r = c;
        for (int i = 0; i < 8; i++) begin
            fb = r[0] ^ d[i];
            r  = {1'b0, r[15:1]};
            if (fb) begin
                r = r ^ 16'hA001;
            end
        end
        return r;
    endfunction : crc16_byte

    logic [15:0] crc_after_cmd;
    logic [15:0] crc_after_lo;
    logic [15:0] crc_after_hi;
    logic [15:0] crc_after_data;

    // generator starts cleared for every write; bytes enter in bus order
    assign crc_after_cmd  = crc16_byte(16'h0000, crc_cmd);
    assign crc_after_lo   = crc16_byte(crc_after_cmd, crc_addr[7:0]);
    assign crc_after_hi   = crc16_byte(crc_after_lo, crc_addr[15:8]);
    assign crc_after_data = crc16_byte(crc_after_hi, stat_wdata); // R20

    // registered so the master sees a stable value
    always_ff @(posedge clk) begin
        if (rst) begin
            write_crc <= 16'h0000;
        end else begin
            write_crc <= ~crc_after_data; // R20
        end
    end
endmodule : ssm_status_mem

// ### test/ssm_status_monitor.sv
// Purpose: port-level checks of the switch status memory
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every status memory instance
`timescale 1ns/10ps
module ssm_status_monitor (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       rom_cmd_stb,
    input wire logic [2:0] stat_addr,
    input wire logic [7:0] stat_rdata,
    input wire logic [6:0] data_page_addr,
    input wire logic       data_prog_req,
    input wire logic       data_prog_ok,
    input wire logic       supply_pin,
    input wire logic       switch_a_oe,
    input wire logic       switch_b_oe,
    input wire logic       switch_a_out,
    input wire logic       switch_b_out,
    input wire logic [7:0] chan_info
);
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic seen_rom_r;
    // first ROM byte since reset; outputs may move only after it
    always_ff @(posedge clk) begin
        if (rst) seen_rom_r <= 1'h0;
        else if (rom_cmd_stb) seen_rom_r <= 1'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // five cycles cover the pin synchroniser and the read register
    sequence s_supply_settled;
        $stable(supply_pin) [*5];
    endsequence
    a_outputs_low: assert property (switch_a_out == 1'h0 && switch_b_out == 1'h0)
        else $error("switch data output not low");
    a_factory_zero: assert property (stat_addr == 3'h5 |=> stat_rdata == 8'h00)
        else $error("factory byte not zero");
    a_redir_fixed: assert property (stat_addr inside {[3'h1:3'h4]} |=> stat_rdata[7:2] == 6'h3F)
        else $error("redirect upper bits cleared");
    a_lock_refuse: assert property ($past(stat_addr) == 3'h0 && !$past(rst) && data_prog_req
        && stat_rdata[data_page_addr[6:5]] == 1'h0 |-> !data_prog_ok)
        else $error("locked page accepted a program");
    a_supply_read: assert property (s_supply_settled and (stat_addr == 3'h7) [*5]
        |-> stat_rdata[7] == supply_pin)
        else $error("supply bit mismatch in live byte");
    a_info_supply: assert property (s_supply_settled |-> chan_info[7] == supply_pin)
        else $error("supply bit mismatch in channel info");
    a_info_flops: assert property (!$past(rst) |-> chan_info[1:0] == ~{$past(switch_b_oe), $past(switch_a_oe)})
        else $error("channel info flops disagree with drive");
    a_off_before_rom: assert property (!seen_rom_r |-> !switch_a_oe && !switch_b_oe)
        else $error("transistor on before defaults loaded");
endmodule : ssm_status_monitor

bind ssm_status_mem ssm_status_monitor u_mon (.clk, .rst, .rom_cmd_stb, .stat_addr, .stat_rdata,
    .data_page_addr, .data_prog_req, .data_prog_ok, .supply_pin, .switch_a_oe, .switch_b_oe,
    .switch_a_out, .switch_b_out, .chan_info);

// ### test/ssm_far_side.sv
// Purpose: pin loads and supply seen by the switch status memory
// Assumes: pull-up on each switch line
// Notes:   behavioural only
`timescale 1ns/10ps
module ssm_far_side (
    input  wire logic supply_on,
    input  wire logic switch_a_oe,
    input  wire logic switch_b_oe,
    output logic      supply_pin,
    output logic      switch_a_pin,
    output logic      switch_b_pin
);
    // pull-up load: a conducting transistor drags its line low
    assign switch_a_pin = ~switch_a_oe;
    assign switch_b_pin = ~switch_b_oe;
    assign supply_pin   = supply_on;
endmodule : ssm_far_side

// ### test/testbench.sv
// Purpose: self-checking bench for the switch status memory
// Assumes: 200 MHz clock, inputs driven 1 ns after rising edge
// Notes:   OTP cells start erased after every reset
`timescale 1ns/10ps
module testbench;
    logic clk, rst, rom_cmd_stb, rom_matched, stat_prog, live_wr, chan_wr, data_prog_req, supply_on;
    logic [2:0] stat_addr;
    logic [7:0] stat_wdata, stat_rdata, chan_info, crc_cmd;
    logic [1:0] chan_wdata;
    logic [6:0] data_page_addr;
    logic [15:0] write_crc, crc_addr;
    logic data_prog_ok, supply_pin, switch_a_pin, switch_b_pin, switch_a_oe, switch_b_oe;
    logic switch_a_out, switch_b_out, concealed, search_eligible;
    int bad_count, checks_done, cycles;
    ssm_status_mem uut (.clk, .rst, .rom_cmd_stb, .rom_matched, .stat_addr, .stat_wdata, .stat_prog,
        .live_wr, .chan_wr, .chan_wdata, .crc_cmd, .crc_addr, .write_crc, .stat_rdata,
        .data_page_addr, .data_prog_req, .data_prog_ok, .supply_pin, .switch_a_pin, .switch_b_pin,
        .switch_a_oe, .switch_b_oe, .switch_a_out, .switch_b_out, .chan_info, .concealed, .search_eligible);
    ssm_far_side u_far (.supply_on, .switch_a_oe, .switch_b_oe, .supply_pin, .switch_a_pin, .switch_b_pin);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8
    // reflected crc16 step, one message byte lsb first
    function automatic logic [15:0] crc_feed(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r >> 1) ^ ((r[0] ^ d[i]) ? 16'hA001 : 16'h0000);
        end
        return r;
    endfunction : crc_feed
    // message followed by the true crc must leave the generator at zero
    task automatic chk_crc;
        logic [15:0] r;
        logic [15:0] sent;
        sent = ~write_crc;
        r = crc_feed(16'h0000, crc_cmd);
        r = crc_feed(r, crc_addr[7:0]);
        r = crc_feed(r, crc_addr[15:8]);
        r = crc_feed(r, stat_wdata);
        r = crc_feed(r, sent[7:0]);
        r = crc_feed(r, sent[15:8]);
        checks_done++;
        if (r !== 16'h0000) begin
            bad_count++;
            $display("ERROR at %0t: write crc %h leaves residual %h", $time, write_crc, r);
        end
    endtask : chk_crc
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        stat_addr = a;
        tick(1);
        chk8(stat_rdata, exp);
    endtask : rd
    // k: 0 program, 1 live write, 2 channel write, 3 ROM byte
    task automatic wr(input int k, input logic [2:0] a, input logic [7:0] d);
        stat_addr = a;
        stat_wdata = d;
        chan_wdata = d[1:0];
        {rom_cmd_stb, chan_wr, live_wr, stat_prog} = 4'h1 << k;
        tick(1);
        {rom_cmd_stb, chan_wr, live_wr, stat_prog} = 4'h0;
        tick(1);
    endtask : wr
    task automatic report_and_stop;
        if (bad_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    // ------------------------------------------------------------
    // clock, timeout and test sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    // hang guard; the sequence needs well under 300 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            report_and_stop;
        end
    end
    initial begin
        {rom_cmd_stb, rom_matched, stat_prog, live_wr, chan_wr, data_prog_req} = 6'h00;
        {stat_addr, stat_wdata, chan_wdata, data_page_addr} = 20'h00000;
        {crc_cmd, crc_addr} = 24'h000000;
        supply_on = 1'h1;
        rst = 1'h1;
        tick(8);
        rst = 1'h0;
        tick(4);
        for (int a = 0; a < 8; a++) rd(a[2:0], a == 5 ? 8'h00 : a == 7 ? 8'hE0 : 8'hFF);
        chk8({6'h00, switch_b_oe, switch_a_oe}, 8'h00);
        wr(1, 3'h7, 8'h1E);
        rd(3'h7, 8'hE0);
        wr(0, 3'h6, 8'h1E);
        wr(0, 3'h6, 8'hFF);
        rd(3'h6, 8'h1E);
        {crc_cmd, crc_addr} = 24'h55_0006;
        wr(0, 3'h6, 8'hFF);
        chk_crc;
        wr(3, 3'h7, 8'h00);
        rd(3'h7, 8'h9E);
        tick(4);
        chk8({5'h00, concealed, switch_b_oe, switch_a_oe}, 8'h03);
        chk8(chan_info, 8'h80);
        wr(2, 3'h7, 8'h01);
        tick(4);
        chk8({6'h00, switch_b_oe, switch_a_oe}, 8'h02);
        chk8(chan_info, 8'h85);
        rd(3'h7, 8'hBE);
        wr(0, 3'h1, 8'h00);
        rd(3'h1, 8'hFC);
        {crc_cmd, crc_addr} = 24'hA5_0001;
        tick(1);
        chk_crc;
        data_page_addr = 7'h40;
        data_prog_req = 1'h1;
        tick(1);
        chk8({7'h00, data_prog_ok}, 8'h01);
        wr(0, 3'h0, 8'hFB);
        chk8({7'h00, data_prog_ok}, 8'h00);
        wr(0, 3'h0, 8'h0B);
        rd(3'h0, 8'h0B);
        data_page_addr = 7'h25;
        tick(1);
        chk8({7'h00, data_prog_ok}, 8'h01);
        supply_on = 1'h0;
        wr(1, 3'h7, 8'hF8);
        tick(4);
        chk8({6'h00, concealed, search_eligible}, 8'h02);
        rd(3'h7, 8'h78);
        wr(1, 3'h7, 8'h79);
        tick(1);
        chk8({6'h00, concealed, search_eligible}, 8'h03);
        rom_matched = 1'h1;
        wr(1, 3'h7, 8'h7B);
        tick(1);
        chk8({7'h00, concealed}, 8'h00);
        rst = 1'h1;
        tick(2);
        rst = 1'h0;
        tick(4);
        rd(3'h7, 8'h60);
        chk8({6'h00, switch_b_oe, switch_a_oe}, 8'h00);
        report_and_stop;
    end
endmodule : testbench
